// File: logic/dpm_pkg.sv
// Constants for the host-side controller of one dual-port RAM port
package dpm_pkg;
  localparam int ADDR_W  = 13;
  localparam int DATA_W  = 18;
  localparam int LANE_W  = 9;
  localparam int CNT_W   = 8;
  localparam int SYNC_STAGES = 2;

  // Mailbox locations: right port owns the highest word, left the next one
  localparam logic [ADDR_W-1:0] MBOX_RIGHT_8K = 13'h1fff;
  localparam logic [ADDR_W-1:0] MBOX_LEFT_8K  = 13'h1ffe;
  localparam logic [ADDR_W-1:0] MBOX_RIGHT_4K = 13'h0fff;
  localparam logic [ADDR_W-1:0] MBOX_LEFT_4K  = 13'h0ffe;

  // Pin timing in ns, then whole clock cycles (least times round up)
  localparam int CLK_NS                    = 10;
  localparam int SELECT_ACCESS_TIME_NS     = 25;
  localparam int WRITE_TO_READ_FLOW_NS     = 30;
  localparam int BUSY_SETTLE_NS            = 25;
  localparam int WRITE_PULSE_NS            = 20;
  localparam int RECOVER_NS                = 15;
  localparam int READ_WAIT_NS = (WRITE_TO_READ_FLOW_NS > SELECT_ACCESS_TIME_NS) ?
                                WRITE_TO_READ_FLOW_NS : SELECT_ACCESS_TIME_NS;

  localparam logic [CNT_W-1:0] SETTLE_CYC =
    CNT_W'((BUSY_SETTLE_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
  // Pin sampled one cycle past the worst-case wait, never on its edge
  localparam logic [CNT_W-1:0] READ_CYC =
    CNT_W'(READ_WAIT_NS / CLK_NS + 1 + SYNC_STAGES);
  localparam logic [CNT_W-1:0] WRITE_CYC =
    CNT_W'((WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] RECOVER_CYC =
    CNT_W'((RECOVER_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  typedef enum logic [2:0] {
    DPM_IDLE    = 3'h0,
    DPM_SETTLE  = 3'h1,
    DPM_ACCESS  = 3'h3,
    DPM_TERM    = 3'h2,
    DPM_RECOVER = 3'h6
  } dpm_state_t;
endpackage

// File: logic/dpm_sync.sv
// Two-stage synchroniser for pins coming from the asynchronous RAM
`timescale 1ns/10ps
module dpm_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;
  logic [WIDTH-1:0] sync_ff;

  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  // Reset to the idle level of active-low pins
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;
endmodule

// File: logic/dpm_host_ctrl.sv
// Host controller that drives one port of an asynchronous dual-port RAM
// Operation
// [RULE1] Device holds shared 4K or 8K array
// [RULE2] Each port accesses any location independently
// [RULE3] Device powers down while chip enable inactive
// [RULE4] Write ends when strobe or enable releases
// [RULE5] Reader waits flowthrough delay after writes
// [RULE6] Reads need chip enable and output enable
// [RULE7] Flag latch access uses its select instead
// [RULE8] Highest address is the right mailbox
// [RULE9] Second-highest address is the left mailbox
// [RULE10] Mailbox write raises owner's interrupt flag
// [RULE11] Owner reading its mailbox clears flag
// [RULE12] Reading other mailbox leaves flags alone
// [RULE13] Busy port cannot raise the interrupt
// [RULE14] Busy port cannot clear its interrupt
// [RULE15] Without messaging, keep interrupt flag unconnected
// [RULE16] Address match grants exactly one port
// [RULE17] Too-close requests still grant one port
// [RULE18] Busy follows match or enable delays
// [RULE19] Master drives busy, slave receives it
// [RULE20] Master busy outputs feed every slave
// [RULE21] Hold writes until busy input settles
// [RULE22] Byte lane selects gate each lane
// [RULE23] Eight flag latches on low address bits
// [RULE24] Busy port's write to location suppressed
`timescale 1ns/10ps
module dpm_host_ctrl (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       sys_rst,
  // User request
  input  wire logic                       req_valid,
  output logic                            req_ready,
  input  wire logic                       req_write,
  input  wire logic                       req_flag,
  input  wire logic [dpm_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [dpm_pkg::DATA_W-1:0] req_wdata,
  input  wire logic [1:0]                 req_lanes,
  // User answer
  output logic                            rsp_done,
  output logic [dpm_pkg::DATA_W-1:0]      rsp_rdata,
  output logic                            rsp_retried,
  // Message passing
  input  wire logic                       mailbox_en,
  output logic                            mailbox_irq,
  // RAM port pins
  output logic                            ram_ce_n,
  output logic                            ram_rw_n,
  output logic                            ram_oe_n,
  output logic [dpm_pkg::ADDR_W-1:0]      ram_addr,
  output logic                            flag_latch_select_n,
  output logic                            upper_lane_select_n,
  output logic                            lower_lane_select_n,
  output logic [dpm_pkg::DATA_W-1:0]      ram_dout,
  output logic                            ram_dout_oe_n,
  input  wire logic [dpm_pkg::DATA_W-1:0] ram_din,
  input  wire logic                       ram_busy_n,
  input  wire logic                       ram_int_n
);
  dpm_pkg::dpm_state_t             state_ff, nxt_state;
  logic [dpm_pkg::CNT_W-1:0]       cnt_ff, nxt_cnt;
  logic                            we_ff, nxt_we;
  logic                            flag_ff, nxt_flag;
  logic                            retry_ff, nxt_retry;
  logic [1:0]                      lanes_ff, nxt_lanes;
  logic                            done_ff, nxt_done;
  logic                            retried_ff, nxt_retried;
  logic                            irq_ff, nxt_irq;
  logic [dpm_pkg::DATA_W-1:0]      rdata_ff, nxt_rdata;
  logic                            ce_n_ff, nxt_ce_n;
  logic                            rw_n_ff, nxt_rw_n;
  logic                            oe_n_ff, nxt_oe_n;
  logic                            sem_n_ff, nxt_sem_n;
  logic                            ub_n_ff, nxt_ub_n;
  logic                            lb_n_ff, nxt_lb_n;
  logic [dpm_pkg::ADDR_W-1:0]      addr_ff, nxt_addr;
  logic [dpm_pkg::DATA_W-1:0]      dout_ff, nxt_dout;
  logic                            dout_oe_n_ff, nxt_dout_oe_n;
  logic [dpm_pkg::DATA_W+1:0]      pins_sync;
  logic [dpm_pkg::DATA_W-1:0]      din_sync;
  logic                            busy_sync_n;
  logic                            int_sync_n;

  // [RULE20] Master busy input
  dpm_sync #(
    .WIDTH (dpm_pkg::DATA_W + 2)
  ) u_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in ({ram_int_n, ram_busy_n, ram_din}),
    .sync_out (pins_sync)
  );

  assign din_sync    = pins_sync[dpm_pkg::DATA_W-1:0];
  assign busy_sync_n = pins_sync[dpm_pkg::DATA_W];
  assign int_sync_n  = pins_sync[dpm_pkg::DATA_W+1];

  always_comb begin
    nxt_state     = state_ff;
    nxt_cnt       = cnt_ff;
    nxt_we        = we_ff;
    nxt_flag      = flag_ff;
    nxt_retry     = retry_ff;
    nxt_lanes     = lanes_ff;
    nxt_done      = 1'b0;
    nxt_retried   = retried_ff;
    nxt_rdata     = rdata_ff;
    nxt_ce_n      = ce_n_ff;
    nxt_rw_n      = rw_n_ff;
    nxt_oe_n      = oe_n_ff;
    nxt_sem_n     = sem_n_ff;
    nxt_ub_n      = ub_n_ff;
    nxt_lb_n      = lb_n_ff;
    nxt_addr      = addr_ff;
    nxt_dout      = dout_ff;
    nxt_dout_oe_n = dout_oe_n_ff;
    // [RULE15] Interrupt only used when messaging
    nxt_irq       = mailbox_en & ~int_sync_n;
    unique case (state_ff)
      dpm_pkg::DPM_IDLE: begin
        if (req_valid) begin
          nxt_we      = req_write;
          nxt_flag    = req_flag;
          nxt_lanes   = req_lanes;
          nxt_addr    = req_addr;
          nxt_dout    = req_wdata;
          nxt_retried = 1'b0;
          // [RULE7] Flag select replaces chip enable
          nxt_ce_n    = req_flag;
          nxt_sem_n   = ~req_flag;
          nxt_ub_n    = req_flag | ~req_lanes[1];
          nxt_lb_n    = req_flag | ~req_lanes[0];
          nxt_cnt     = dpm_pkg::SETTLE_CYC - dpm_pkg::CNT_ONE;
          nxt_state   = dpm_pkg::DPM_SETTLE;
        end
      end
      dpm_pkg::DPM_SETTLE: begin
        if (cnt_ff != dpm_pkg::CNT_ZERO) begin
          nxt_cnt = cnt_ff - dpm_pkg::CNT_ONE;
        end else if (!flag_ff && !busy_sync_n) begin
          // Lost arbitration: release the port and try again
          nxt_ce_n    = 1'b1;
          nxt_ub_n    = 1'b1;
          nxt_lb_n    = 1'b1;
          nxt_retry   = 1'b1;
          nxt_retried = 1'b1;
          nxt_cnt     = dpm_pkg::RECOVER_CYC - dpm_pkg::CNT_ONE;
          nxt_state   = dpm_pkg::DPM_RECOVER;
        end else if (we_ff) begin
          // [RULE21] Write starts after busy settled
          nxt_rw_n      = 1'b0;
          nxt_dout_oe_n = 1'b0;
          nxt_cnt       = dpm_pkg::WRITE_CYC - dpm_pkg::CNT_ONE;
          nxt_state     = dpm_pkg::DPM_ACCESS;
        end else begin
          // [RULE6] Output enable with select held
          nxt_oe_n  = 1'b0;
          nxt_cnt   = dpm_pkg::READ_CYC - dpm_pkg::CNT_ONE;
          nxt_state = dpm_pkg::DPM_ACCESS;
        end
      end
      dpm_pkg::DPM_ACCESS: begin
        if (cnt_ff != dpm_pkg::CNT_ZERO) begin
          nxt_cnt = cnt_ff - dpm_pkg::CNT_ONE;
        end else begin
          // [RULE4] Strobe releases first, ending write
          nxt_rw_n = 1'b1;
          nxt_oe_n = 1'b1;
          // [RULE5] Capture only after flowthrough wait
          if (!we_ff) begin
            nxt_rdata = din_sync;
          end
          nxt_state = dpm_pkg::DPM_TERM;
        end
      end
      dpm_pkg::DPM_TERM: begin
        nxt_ce_n      = 1'b1;
        nxt_sem_n     = 1'b1;
        nxt_ub_n      = 1'b1;
        nxt_lb_n      = 1'b1;
        nxt_dout_oe_n = 1'b1;
        nxt_cnt       = dpm_pkg::RECOVER_CYC - dpm_pkg::CNT_ONE;
        nxt_state     = dpm_pkg::DPM_RECOVER;
      end
      dpm_pkg::DPM_RECOVER: begin
        if (cnt_ff != dpm_pkg::CNT_ZERO) begin
          nxt_cnt = cnt_ff - dpm_pkg::CNT_ONE;
        end else if (retry_ff) begin
          nxt_retry = 1'b0;
          nxt_ce_n  = 1'b0;
          nxt_ub_n  = ~lanes_ff[1];
          nxt_lb_n  = ~lanes_ff[0];
          nxt_cnt   = dpm_pkg::SETTLE_CYC - dpm_pkg::CNT_ONE;
          nxt_state = dpm_pkg::DPM_SETTLE;
        end else begin
          nxt_done  = 1'b1;
          nxt_state = dpm_pkg::DPM_IDLE;
        end
      end
      default: begin
        nxt_state = dpm_pkg::DPM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_ff     <= dpm_pkg::DPM_IDLE;
      cnt_ff       <= '0;
      we_ff        <= 1'b0;
      flag_ff      <= 1'b0;
      retry_ff     <= 1'b0;
      lanes_ff     <= 2'h0;
      done_ff      <= 1'b0;
      retried_ff   <= 1'b0;
      irq_ff       <= 1'b0;
      rdata_ff     <= '0;
      ce_n_ff      <= 1'b1;
      rw_n_ff      <= 1'b1;
      oe_n_ff      <= 1'b1;
      sem_n_ff     <= 1'b1;
      ub_n_ff      <= 1'b1;
      lb_n_ff      <= 1'b1;
      addr_ff      <= '0;
      dout_ff      <= '0;
      dout_oe_n_ff <= 1'b1;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      we_ff        <= nxt_we;
      flag_ff      <= nxt_flag;
      retry_ff     <= nxt_retry;
      lanes_ff     <= nxt_lanes;
      done_ff      <= nxt_done;
      retried_ff   <= nxt_retried;
      irq_ff       <= nxt_irq;
      rdata_ff     <= nxt_rdata;
      ce_n_ff      <= nxt_ce_n;
      rw_n_ff      <= nxt_rw_n;
      oe_n_ff      <= nxt_oe_n;
      sem_n_ff     <= nxt_sem_n;
      ub_n_ff      <= nxt_ub_n;
      lb_n_ff      <= nxt_lb_n;
      addr_ff      <= nxt_addr;
      dout_ff      <= nxt_dout;
      dout_oe_n_ff <= nxt_dout_oe_n;
    end
  end

  assign req_ready           = (state_ff == dpm_pkg::DPM_IDLE);
  assign rsp_done            = done_ff;
  assign rsp_rdata           = rdata_ff;
  assign rsp_retried         = retried_ff;
  assign mailbox_irq         = irq_ff;
  assign ram_ce_n            = ce_n_ff;
  assign ram_rw_n            = rw_n_ff;
  assign ram_oe_n            = oe_n_ff;
  assign ram_addr            = addr_ff;
  assign flag_latch_select_n = sem_n_ff;
  assign upper_lane_select_n = ub_n_ff;
  assign lower_lane_select_n = lb_n_ff;
  assign ram_dout            = dout_ff;
  assign ram_dout_oe_n       = dout_oe_n_ff;

  // Cycle counters read only by the checks below
  logic [dpm_pkg::CNT_W-1:0] sel_cnt_ff;
  logic [dpm_pkg::CNT_W-1:0] oe_cnt_ff;
  always_ff @(posedge clock) begin
    if (sys_rst || (ram_ce_n && flag_latch_select_n)) begin
      sel_cnt_ff <= '0;
    end else if (sel_cnt_ff != 8'hff) begin
      sel_cnt_ff <= sel_cnt_ff + dpm_pkg::CNT_ONE;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst || ram_oe_n) begin
      oe_cnt_ff <= '0;
    end else if (oe_cnt_ff != 8'hff) begin
      oe_cnt_ff <= oe_cnt_ff + dpm_pkg::CNT_ONE;
    end
  end

  chk_write_ends_strobe: assert property (@(posedge clock) disable iff (sys_rst) // [RULE4]
    $rose(ram_ce_n) |-> $past(ram_rw_n))
    else $error("chip enable released while write strobe active");
  chk_write_data_held: assert property (@(posedge clock) disable iff (sys_rst) // [RULE4]
    $rose(ram_rw_n) |-> !ram_dout_oe_n && (!ram_ce_n || !flag_latch_select_n) &&
      $stable(ram_dout))
    else $error("write data not held at strobe release");
  chk_read_flow_wait: assert property (@(posedge clock) disable iff (sys_rst) // [RULE5]
    $rose(ram_oe_n) |-> oe_cnt_ff == dpm_pkg::READ_CYC)
    else $error("read ended before flowthrough wait");
  chk_read_needs_enable: assert property (@(posedge clock) disable iff (sys_rst) // [RULE6]
    !ram_oe_n |-> (!ram_ce_n || !flag_latch_select_n) && ram_rw_n && ram_dout_oe_n)
    else $error("output enable without select");
  chk_flag_select_excl: assert property (@(posedge clock) disable iff (sys_rst) // [RULE7]
    !flag_latch_select_n |-> ram_ce_n && upper_lane_select_n && lower_lane_select_n)
    else $error("flag select with chip enable or lanes");
  chk_irq_gated_use: assert property (@(posedge clock) disable iff (sys_rst) // [RULE15]
    mailbox_irq |-> $past(mailbox_en) && $past(!int_sync_n))
    else $error("interrupt forwarded without messaging");
  chk_write_after_settle: assert property (@(posedge clock) disable iff (sys_rst) // [RULE21]
    $fell(ram_rw_n) |-> sel_cnt_ff == dpm_pkg::SETTLE_CYC && $past(busy_sync_n))
    else $error("write started before busy settled");

  cov_write_done: cover property (@(posedge clock) disable iff (sys_rst)
    rsp_done && we_ff && !flag_ff);
  cov_read_done: cover property (@(posedge clock) disable iff (sys_rst)
    rsp_done && !we_ff && !flag_ff);
  cov_busy_retry: cover property (@(posedge clock) disable iff (sys_rst)
    rsp_done && rsp_retried);
  cov_flag_access: cover property (@(posedge clock) disable iff (sys_rst)
    rsp_done && flag_ff);
endmodule

// File: bench/dpm_ram_model.sv
// Behavioural model of the dual-port RAM seen from the host port, with its peer port
`timescale 1ns/10ps
module dpm_ram_model (
  // Host port pins
  input  wire logic                       ram_ce_n,
  input  wire logic                       ram_rw_n,
  input  wire logic                       ram_oe_n,
  input  wire logic [dpm_pkg::ADDR_W-1:0] ram_addr,
  input  wire logic                       flag_latch_select_n,
  input  wire logic                       upper_lane_select_n,
  input  wire logic                       lower_lane_select_n,
  input  wire logic [dpm_pkg::DATA_W-1:0] ram_dout,
  input  wire logic                       ram_dout_oe_n,
  output logic      [dpm_pkg::DATA_W-1:0] ram_din,
  output logic                            ram_busy_n,
  output logic                            ram_int_n,
  // Peer port
  input  wire logic                       peer_wr,
  input  wire logic                       peer_hold,
  input  wire logic [dpm_pkg::ADDR_W-1:0] peer_addr,
  input  wire logic [dpm_pkg::DATA_W-1:0] peer_data,
  output logic                            peer_int_n
);
  logic [dpm_pkg::DATA_W-1:0] mem [0:8191];
  logic [7:0]                 flags = 8'hff;
  logic [dpm_pkg::DATA_W-1:0] mask;
  logic [dpm_pkg::DATA_W-1:0] bus;
  logic [dpm_pkg::DATA_W-1:0] last_bus = 18'h00000;
  logic                       rd_on;
  logic                       flg;

  initial begin
    ram_int_n = 1'b1;
    peer_int_n = 1'b1;
  end
  assign flg = ~flag_latch_select_n;
  assign mask = flg ? 18'h3ffff : {{9{~upper_lane_select_n}}, {9{~lower_lane_select_n}}};
  assign #20 ram_busy_n = ~(peer_hold & ~ram_ce_n);
  // Drive only while a read is enabled
  assign rd_on = ~ram_oe_n & ram_rw_n & (~ram_ce_n | flg);
  // Selected lanes after delay, released lanes toggle
  always @* begin
    if (!ram_dout_oe_n)
      bus = ram_dout;
    else if (rd_on)
      bus = ((flg ? {18{flags[ram_addr[2:0]]}} : mem[ram_addr]) & mask) | (~last_bus & ~mask);
    else
      bus = ~last_bus;
  end
  assign #30 ram_din = bus;
  always @(ram_din) last_bus = (^ram_din === 1'bx) ? 18'h00000 : ram_din;

  // Commit on first released strobe unless busy
  task automatic commit(input logic to_flag);
    if (to_flag)
      flags[ram_addr[2:0]] = ram_dout[0];
    else if (ram_busy_n) begin
      mem[ram_addr] = (ram_dout & mask) | (mem[ram_addr] & ~mask);
      // Write to peer mailbox raises peer flag
      if (ram_addr == dpm_pkg::MBOX_RIGHT_8K) peer_int_n = 1'b0;
    end
  endtask
  always @(posedge ram_rw_n) if (!ram_ce_n || flg) commit(flg);
  always @(posedge ram_ce_n) if (!ram_rw_n) commit(1'b0);
  always @(posedge flag_latch_select_n) if (!ram_rw_n) commit(1'b1);

  // Peer write to host mailbox raises host flag
  always @(posedge peer_wr) begin
    mem[peer_addr] = peer_data;
    if (peer_addr == dpm_pkg::MBOX_LEFT_8K) ram_int_n = 1'b0;
  end
  // Only an unbusy owner read clears the flag
  always @* if (rd_on && !flg && ram_busy_n && ram_addr == dpm_pkg::MBOX_LEFT_8K) ram_int_n = 1'b1;
endmodule

// File: bench/test_dpm_host_ctrl.sv
// Self-checking testbench for the dual-port RAM host controller
`timescale 1ns/10ps
module test_dpm_host_ctrl;
  logic                       clock, sys_rst, req_valid, req_ready, req_write, req_flag;
  logic [dpm_pkg::ADDR_W-1:0] req_addr, ram_addr, peer_addr;
  logic [dpm_pkg::DATA_W-1:0] req_wdata, rsp_rdata, ram_dout, ram_din, peer_data;
  logic [1:0]                 req_lanes;
  logic                       rsp_done, rsp_retried, mailbox_en, mailbox_irq;
  logic                       ram_ce_n, ram_rw_n, ram_oe_n, flag_latch_select_n;
  logic                       upper_lane_select_n, lower_lane_select_n, ram_dout_oe_n;
  logic                       ram_busy_n, ram_int_n, peer_wr, peer_hold, peer_int_n, ce_seen;
  int                         num_errors = 0;
  int                         samples_checked = 0;

  dpm_host_ctrl u_dpm_host_ctrl (
    .clock(clock), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_flag(req_flag), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_lanes(req_lanes), .rsp_done(rsp_done), .rsp_rdata(rsp_rdata),
    .rsp_retried(rsp_retried), .mailbox_en(mailbox_en), .mailbox_irq(mailbox_irq),
    .ram_ce_n(ram_ce_n), .ram_rw_n(ram_rw_n), .ram_oe_n(ram_oe_n), .ram_addr(ram_addr),
    .flag_latch_select_n(flag_latch_select_n), .upper_lane_select_n(upper_lane_select_n),
    .lower_lane_select_n(lower_lane_select_n), .ram_dout(ram_dout),
    .ram_dout_oe_n(ram_dout_oe_n), .ram_din(ram_din), .ram_busy_n(ram_busy_n),
    .ram_int_n(ram_int_n));
  dpm_ram_model u_dpm_ram_model (
    .ram_ce_n(ram_ce_n), .ram_rw_n(ram_rw_n), .ram_oe_n(ram_oe_n), .ram_addr(ram_addr),
    .flag_latch_select_n(flag_latch_select_n), .upper_lane_select_n(upper_lane_select_n),
    .lower_lane_select_n(lower_lane_select_n), .ram_dout(ram_dout),
    .ram_dout_oe_n(ram_dout_oe_n), .ram_din(ram_din), .ram_busy_n(ram_busy_n),
    .ram_int_n(ram_int_n), .peer_wr(peer_wr), .peer_hold(peer_hold), .peer_addr(peer_addr),
    .peer_data(peer_data), .peer_int_n(peer_int_n));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) if (!ram_ce_n) ce_seen <= 1'b1;

  task automatic give_verdict();
    $display("Checks made: %0d, mismatches: %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check_word(input string what, input logic [17:0] exp, input logic [17:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    check_word(what, {17'h00000, exp}, {17'h00000, got});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic peer_write(input logic [12:0] a, input logic [17:0] d);
    peer_addr = a;
    peer_data = d;
    peer_wr = 1'b1;
    #5;
    peer_wr = 1'b0;
  endtask

  // One request, held for one clock, then waits for completion
  task automatic access(input logic wr, input logic flg, input logic [12:0] a,
                        input logic [17:0] d, input logic [1:0] ln, input int lat);
    int cyc;
    req_write = wr;
    req_flag = flg;
    req_addr = a;
    req_wdata = d;
    req_lanes = ln;
    req_valid = 1'b1;
    wait_cyc(1);
    req_valid = 1'b0;
    cyc = 0;
    while (rsp_done !== 1'b1 && cyc < 400) begin
      wait_cyc(1);
      cyc++;
    end
    if (lat != 0 || cyc == 400) check_word("latency", 18'(lat), 18'(cyc));
  endtask

  task automatic t_reset();
    check_word("idle pins", 18'h000ff, {10'h000, ram_ce_n, ram_rw_n, ram_oe_n,
      flag_latch_select_n, upper_lane_select_n, lower_lane_select_n, ram_dout_oe_n, req_ready});
  endtask

  task automatic t_word();
    access(1'b1, 1'b0, 13'h0123, 18'h2a5c3, 2'b11, 10);
    access(1'b1, 1'b0, 13'h1000, 18'h1b00e, 2'b11, 10);
    access(1'b0, 1'b0, 13'h0123, 18'h00000, 2'b11, 14);
    check_word("read 0123", 18'h2a5c3, rsp_rdata);
    access(1'b0, 1'b0, 13'h1000, 18'h00000, 2'b11, 14);
    check_word("read 1000", 18'h1b00e, rsp_rdata);
    peer_write(13'h0456, 18'h3c0f1);
    access(1'b0, 1'b0, 13'h0456, 18'h00000, 2'b11, 14);
    check_word("peer data", 18'h3c0f1, rsp_rdata);
  endtask

  task automatic t_lanes();
    access(1'b1, 1'b0, 13'h0042, 18'h3ffff, 2'b11, 10);
    access(1'b1, 1'b0, 13'h0042, 18'h00000, 2'b10, 10);
    access(1'b0, 1'b0, 13'h0042, 18'h00000, 2'b11, 14);
    check_word("upper lane", 18'h001ff, rsp_rdata);
    access(1'b1, 1'b0, 13'h0042, 18'h00000, 2'b01, 10);
    access(1'b0, 1'b0, 13'h0042, 18'h00000, 2'b11, 14);
    check_word("lower lane", 18'h00000, rsp_rdata);
  endtask

  task automatic t_flag();
    ce_seen = 1'b0;
    access(1'b1, 1'b1, 13'h0005, 18'h00000, 2'b00, 10);
    access(1'b0, 1'b1, 13'h0005, 18'h3ffff, 2'b00, 14);
    check_word("flag 5", 18'h00000, rsp_rdata);
    access(1'b0, 1'b1, 13'h0004, 18'h00000, 2'b00, 14);
    check_word("flag 4", 18'h3ffff, rsp_rdata);
    check_bit("enable in flag access", 1'b0, ce_seen);
  endtask

  task automatic t_mailbox();
    peer_write(dpm_pkg::MBOX_LEFT_8K, 18'h0beef);
    wait_cyc(4);
    check_bit("irq set", 1'b1, mailbox_irq);
    access(1'b0, 1'b0, dpm_pkg::MBOX_RIGHT_8K, 18'h00000, 2'b11, 14);
    wait_cyc(4);
    check_bit("irq kept", 1'b1, mailbox_irq);
    access(1'b0, 1'b0, dpm_pkg::MBOX_LEFT_8K, 18'h00000, 2'b11, 14);
    check_word("mailbox data", 18'h0beef, rsp_rdata);
    wait_cyc(4);
    check_bit("irq cleared", 1'b0, mailbox_irq);
    access(1'b1, 1'b0, dpm_pkg::MBOX_RIGHT_8K, 18'h00abc, 2'b11, 10);
    check_bit("peer flag", 1'b0, peer_int_n);
    mailbox_en = 1'b0;
    peer_write(dpm_pkg::MBOX_LEFT_8K, 18'h00001);
    wait_cyc(4);
    check_bit("irq unused", 1'b0, mailbox_irq);
    mailbox_en = 1'b1;
    wait_cyc(4);
    check_bit("irq used", 1'b1, mailbox_irq);
  endtask

  task automatic t_busy();
    peer_hold = 1'b1;
    fork
      access(1'b0, 1'b0, dpm_pkg::MBOX_LEFT_8K, 18'h00000, 2'b11, 0);
      begin
        wait_cyc(40);
        check_bit("irq under busy", 1'b1, mailbox_irq);
        peer_hold = 1'b0;
      end
    join
    check_bit("retried", 1'b1, rsp_retried);
    wait_cyc(4);
    check_bit("irq after busy", 1'b0, mailbox_irq);
    peer_hold = 1'b1;
    fork
      access(1'b1, 1'b0, 13'h0077, 18'h15555, 2'b11, 0);
      begin
        wait_cyc(10);
        peer_write(13'h0077, 18'h0aaaa);
        wait_cyc(20);
        peer_hold = 1'b0;
      end
    join
    access(1'b0, 1'b0, 13'h0077, 18'h00000, 2'b11, 14);
    check_bit("retried clear", 1'b0, rsp_retried);
    check_word("winner data", 18'h15555, rsp_rdata);
  endtask

  initial begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_flag = 1'b0;
    req_addr = 13'h0000;
    req_wdata = 18'h00000;
    req_lanes = 2'b00;
    mailbox_en = 1'b1;
    peer_wr = 1'b0;
    peer_hold = 1'b0;
    peer_addr = 13'h0000;
    peer_data = 18'h00000;
    ce_seen = 1'b0;
    repeat (16) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    wait_cyc(1);
    t_reset();
    t_word();
    t_lanes();
    t_flag();
    t_mailbox();
    t_busy();
    give_verdict();
  end

  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
endmodule
